//--- sar_adc_serial_control_tb.sv
// Testbench: controller and converter ends joined over the serial link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
end
module sar_adc_serial_control_tb
    import sasc_pkg::*;
;
    logic clk_sys, resetn, dev_resetn, wr, rd, comparator_above;
    logic powered, internal_clock_mode, sgl;
    logic acquiring, holding, result_ready;
    logic [15:0] exp_avg;
    int acq_cnt, hold_cnt;
    // Positive input per channel field value, three bits each, field 0
    // lowest; a differential pair's negative side is its partner.
    localparam logic [23:0] POS_IDX = 24'hF59D10;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, dac_code, result_code, vin, st, rv, v;
    logic [7:0] pos_sel, exp_pos;
    logic [8:0] neg_sel, exp_neg;
    logic [2:0] ch;
    logic [1:0] pm;
    int error_cnt, checks_done;

    sasc_link_if i_sasc_link_if();
    sasc_host i_sasc_host(.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link(i_sasc_link_if));
    sasc_device i_sasc_device(.link(i_sasc_link_if), .resetn(dev_resetn),
        .comparator_above(comparator_above), .dac_code(dac_code),
        .pos_sel(pos_sel), .neg_sel(neg_sel), .acquiring(acquiring),
        .holding(holding), .powered(powered),
        .internal_clock_mode(internal_clock_mode),
        .result_code(result_code), .result_ready(result_ready));
    sasc_link_sva i_sasc_link_sva(.cs_n(i_sasc_link_if.cs_n),
        .sclk(i_sasc_link_if.sclk), .din(i_sasc_link_if.din),
        .dout(i_sasc_link_if.dout), .dout_oe_n(i_sasc_link_if.dout_oe_n),
        .busy(i_sasc_link_if.busy), .busy_oe_n(i_sasc_link_if.busy_oe_n),
        .resetn(dev_resetn));

    // Ideal front end, so a correct search must return the input code.
    assign comparator_above = (vin >= dac_code);

    // Phase lengths in serial clocks; a falling select starts a frame.
    always @(posedge i_sasc_link_if.sclk or negedge i_sasc_link_if.cs_n) begin
        if (!i_sasc_link_if.sclk) begin
            acq_cnt <= 0;
            hold_cnt <= 0;
        end else begin
            acq_cnt <= acq_cnt + int'(acquiring);
            hold_cnt <= hold_cnt + int'(holding);
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Software port tasks, entered just after a rising edge
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk_sys);
    endtask : rd_reg

    task automatic wait_done(output logic [15:0] s);
        int n;
        n = 0;
        s = 16'h0000;
        while (s[STAT_DONE] !== 1'b1 && n < 300) begin
            rd_reg(ADDR_STAT, s);
            n++;
        end
        `CHK(s[STAT_DONE], 1'b1)
    endtask : wait_done

    task automatic run(input logic [7:0] cmd, input logic [15:0] val);
        logic [16:0] avg_acc;
        vin = val;
        avg_acc = {1'b0, exp_avg} + {1'b0, val};
        exp_avg = avg_acc[16:1];
        wr_reg(ADDR_CMD, {8'h00, cmd});
        wait_done(st);
    endtask : run

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        dev_resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        vin = 16'h0000;
        exp_avg = 16'h0000;
        error_cnt = 0;
        checks_done = 0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        // The converter only sees clocks inside a frame, so reset spans one.
        run(8'h8F, 16'h0000);
        // A converter held in reset selects no input at all.
        `CHK(pos_sel, 8'h00)
        `CHK(neg_sel, 9'h000)
        `CHK(powered, 1'b1)
        `CHK(internal_clock_mode, 1'b0)
        dev_resetn <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            ch = 3'(i);
            sgl = ~i[3];
            v = (i == 15) ? 16'hFFFF : 16'(i * 4099);
            run({1'b1, ch, 1'b0, sgl, PM_EXT}, v);
            exp_pos = 8'h01 << POS_IDX[3 * ch +: 3];
            exp_neg = sgl ? 9'h100 : 9'h001 << (POS_IDX[3 * ch +: 3] ^ 3'h1);
            `CHK(pos_sel, exp_pos)
            `CHK(neg_sel, exp_neg)
            `CHK(st[STAT_BUSY], 1'b1)
            `CHK(result_code, v)
            `CHK(result_ready, 1'b1)
            `CHK(acq_cnt, 4)
            `CHK(hold_cnt, 16)
            rd_reg(ADDR_RES, rv);
            `CHK(rv, v)
            rd_reg(ADDR_CMD, rv);
            `CHK(rv, {8'h00, 1'b1, ch, 1'b0, sgl, PM_EXT})
        end
        for (int k = 0; k < 4; k++) begin
            pm = (k == 0) ? PM_INT : (k == 1) ? PM_AUTO_PD :
                 (k == 2) ? PM_EXT : PM_RSV;
            run({6'h29, pm}, 16'h5A5A);
            `CHK(internal_clock_mode, k < 2)
            `CHK(powered, k != 1)
            `CHK(st[STAT_BUSY], k > 1)
        end
        // A command written mid-frame must not disturb the running one.
        vin = 16'h3C3C;
        wr_reg(ADDR_CMD, 16'h00B7);
        repeat (20) @(posedge clk_sys);
        run(8'hC3, 16'h3C3C);
        rd_reg(ADDR_CMD, rv);
        `CHK(rv, 16'h00B7)
        `CHK(pos_sel, 8'h40)
        rd_reg(ADDR_RES, rv);
        `CHK(rv, 16'h3C3C)
        rd_reg(ADDR_AVG, rv);
        `CHK(rv, exp_avg)
        rd_reg(4'hF, rv);
        `CHK(rv, 16'h0000)
        end_sim();
    end
endmodule : sar_adc_serial_control_tb
`default_nettype wire

//--- sasc_device.sv
// Converter end: control byte capture, multiplexer, SAR sequencing.
//
// Summary of operation
// - Mux configured only from serial control bits.
// - Four-wire link: select, clock, data in/out.
// - Single-ended: channel to positive, common negative.
// - Differential: pair by low bits, top swaps.
// - Whole conversion fits three bytes, 24 clocks.
// - Control byte occupies first eight clocks.
// - Enough bits in: set mux, start acquiring.
// - Four clocks later: hold and convert.
// - Sixteen host clocks after byte perform conversion.
// - Result is 16-bit unsigned, step ref/65536.
// - Host may average results to cut noise.
// - Start bit high; ignore input until seen.
// - Byte MSB first: S, channel, -, mode, power.
// - Power field: 00 auto off, 10 int, 11 ext.
// - External mode: busy one clock, 16 bits out.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sasc_device
    import sasc_pkg::*;
(
    // Link
    sasc_link_if.device link,
    // Power-on reset, synchronous to the serial clock
    input wire logic resetn,
    // Analog front end
    input wire logic comparator_above,
    output logic [15:0] dac_code,
    output logic [7:0] pos_sel,
    output logic [8:0] neg_sel,
    output logic acquiring,
    output logic holding,
    output logic powered,
    output logic internal_clock_mode,
    // Converted result
    output logic [15:0] result_code,
    output logic result_ready
);

    // ------------------------------------------------------------
    // Frame position
    // ------------------------------------------------------------
    // The count is the number of rising edges seen in this frame.
    // Raising select clears it at once, since the serial clock may
    // stop and never deliver an edge to clear it synchronously.
    logic [4:0] cnt_reg;
    logic [6:0] shift_reg;
    logic [2:0] chan_reg;
    logic single_reg;
    logic [1:0] pm_reg;
    logic [15:0] sar_next;
    logic [15:0] trial_mask;
    logic [3:0] out_idx;
    logic frame_busy;

    assign frame_busy = (cnt_reg != CNT_IDLE) && (cnt_reg != CNT_LAST);

    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            cnt_reg <= CNT_IDLE;
        end else if (!resetn) begin
            cnt_reg <= CNT_IDLE;
        end else if (!frame_busy) begin
            // Idle or just after the last decision: a new start bit
            // may overlap the last result bit on the output.
            cnt_reg <= link.din ? 5'h01 : CNT_IDLE;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Control byte capture
    // ------------------------------------------------------------
    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            shift_reg <= 7'h00;
        end else if (!frame_busy) begin
            shift_reg <= {6'h00, link.din};
        end else begin
            shift_reg <= {shift_reg[5:0], link.din};
        end
    end

    // Settings survive between frames; only the byte changes them.
    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            chan_reg <= RST_CHAN;
            single_reg <= 1'b1;
            pm_reg <= RST_PM;
            internal_clock_mode <= 1'b0;
        end else if (!link.cs_n) begin
            if (cnt_reg == CNT_ACQ) begin
                chan_reg <= {shift_reg[1:0], link.din};
            end
            if (cnt_reg == CNT_MODE) begin
                single_reg <= link.din;
            end
            if (cnt_reg == CNT_CTRL) begin
                pm_reg <= {shift_reg[0], link.din};
                // Reserved and auto power-down keep the clock mode.
                if ({shift_reg[0], link.din} == PM_INT) begin
                    internal_clock_mode <= 1'b1;
                end else if ({shift_reg[0], link.din} == PM_EXT) begin
                    internal_clock_mode <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Multiplexer and sample phases
    // ------------------------------------------------------------
    // Mode bit arrives two clocks into acquisition, so the previous
    // mode rules the mux until then.
    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            pos_sel <= 8'h00;
            neg_sel <= 9'h000;
        end else begin
            pos_sel <= sasc_pos_sel(chan_reg);
            neg_sel <= sasc_neg_sel(chan_reg, single_reg);
        end
    end

    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            acquiring <= 1'b0;
            holding <= 1'b0;
        end else if (!resetn) begin
            acquiring <= 1'b0;
            holding <= 1'b0;
        end else begin
            if (cnt_reg == CNT_ACQ) begin
                acquiring <= 1'b1;
            end else if (cnt_reg == CNT_CTRL) begin
                acquiring <= 1'b0;
            end
            if (cnt_reg == CNT_CTRL) begin
                holding <= 1'b1;
            end else if (cnt_reg == CNT_LAST_DEC) begin
                holding <= 1'b0;
            end
        end
    end

    // Auto power-down drops power at the last decision and wakes on the
    // start bit, because no serial clock follows the frame to do it.
    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            powered <= 1'b1;
        end else if (frame_busy) begin
            powered <= (pm_reg != PM_AUTO_PD)
                       || (cnt_reg != CNT_LAST_DEC);
        end else begin
            powered <= (pm_reg != PM_AUTO_PD) || link.din;
        end
    end

    // ------------------------------------------------------------
    // Successive approximation
    // ------------------------------------------------------------
    // One decision per clock after the byte: keep or drop the trial
    // bit, then try the next lower bit.
    assign trial_mask = SAR_MSB >> 4'(cnt_reg - CNT_DEC0);
    assign sar_next = (comparator_above ? dac_code : dac_code & ~trial_mask)
                      | (trial_mask >> 1);

    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            dac_code <= 16'h0000;
        end else if (!link.cs_n && cnt_reg == CNT_CTRL) begin
            dac_code <= SAR_MSB;
        end else if (!link.cs_n && holding) begin
            dac_code <= sar_next;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (!resetn) begin
            result_code <= 16'h0000;
            result_ready <= 1'b0;
        end else begin
            result_ready <= 1'b0;
            if (!link.cs_n && cnt_reg == CNT_LAST_DEC) begin
                result_code <= sar_next;
                result_ready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Output side, updated on falling edges
    // ------------------------------------------------------------
    // Reads the rising-edge count half a clock later; same clock,
    // so no crossing is needed.
    assign out_idx = 4'(CNT_LAST - cnt_reg);

    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            link.dout <= 1'b0;
            link.dout_oe_n <= 1'b1;
            link.busy <= 1'b0;
            link.busy_oe_n <= 1'b1;
        end else if (!resetn) begin
            link.dout <= 1'b0;
            link.dout_oe_n <= 1'b1;
            link.busy <= 1'b0;
            link.busy_oe_n <= 1'b1;
        end else begin
            link.dout_oe_n <= 1'b0;
            link.busy_oe_n <= 1'b0;
            link.busy <= (cnt_reg == CNT_BUSY)
                         && !internal_clock_mode;
            if (cnt_reg >= CNT_FIRST_OUT) begin
                link.dout <= dac_code[out_idx];
            end else begin
                link.dout <= 1'b0;
            end
        end
    end

endmodule : sasc_device
`default_nettype wire

//--- sasc_host.sv
// Controller end: runs 24-clock frames and holds result registers.
`timescale 1ns/1ps
`default_nettype none
module sasc_host
    import sasc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Software port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Link
    sasc_link_if.host link
);

    // ------------------------------------------------------------
    // Link inputs
    // ------------------------------------------------------------
    logic [1:0] link_sync;
    logic dout_s;
    logic busy_s;

    sasc_sync2 u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d_async({link.busy, link.dout}),
        .q_sync(link_sync)
    );
    assign dout_s = link_sync[0];
    assign busy_s = link_sync[1];

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // Each half period is four system clocks, enough for a falling
    // edge output change to clear the synchroniser before sampling.
    sasc_host_st_t st_reg;
    logic [2:0] div_reg;
    logic [4:0] edge_reg;
    logic [7:0] tx_reg;
    logic [15:0] rx_reg;
    logic [15:0] result_reg;
    logic [15:0] avg_reg;
    logic [16:0] avg_sum;
    logic cs_n_reg;
    logic sclk_reg;
    logic din_reg;
    logic done_reg;
    logic busy_seen_reg;
    logic half_end;
    logic start_cmd;
    logic frame_end;

    assign half_end = (div_reg == HALF_LAST);
    assign start_cmd = wr && (addr == ADDR_CMD) && (st_reg == H_IDLE);
    assign frame_end = (st_reg == H_TAIL) && half_end;
    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.din = din_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn || st_reg == H_IDLE) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= half_end ? 3'h0 : div_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= H_IDLE;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            din_reg <= 1'b0;
            edge_reg <= 5'h00;
            tx_reg <= 8'h00;
            rx_reg <= 16'h0000;
        end else begin
            case (st_reg)
                H_IDLE: begin
                    if (start_cmd) begin
                        // Start bit forced high, byte sent MSB first.
                        tx_reg <= {1'b1, wdata[6:0]};
                        din_reg <= 1'b1;
                        cs_n_reg <= 1'b0;
                        edge_reg <= 5'h00;
                        st_reg <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        sclk_reg <= 1'b1;
                        edge_reg <= edge_reg + 5'h01;
                        if (edge_reg >= CNT_RX_FIRST) begin
                            rx_reg <= {rx_reg[14:0], dout_s};
                        end
                        st_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        sclk_reg <= 1'b0;
                        if (edge_reg < 5'(CTRL_BITS)) begin
                            din_reg <= tx_reg[3'(START_POS) - edge_reg[2:0]];
                        end else begin
                            din_reg <= 1'b0;
                        end
                        // Clocks run unbroken: 24 edges per frame.
                        st_reg <= (edge_reg == CNT_LAST)
                                  ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL: begin
                    if (half_end) begin
                        // The last bit is on the line after the final
                        // falling edge, so no extra clock is needed.
                        rx_reg <= {rx_reg[14:0], dout_s};
                        cs_n_reg <= 1'b1;
                        st_reg <= H_IDLE;
                    end
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results and status
    // ------------------------------------------------------------
    assign avg_sum = {1'b0, avg_reg} + {1'b0, rx_reg[14:0], dout_s};

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            result_reg <= 16'h0000;
            avg_reg <= 16'h0000;
        end else if (frame_end) begin
            result_reg <= {rx_reg[14:0], dout_s};
            avg_reg <= avg_sum[16:1];
        end
    end

    // A new completion wins over a status read in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else if (frame_end) begin
            done_reg <= 1'b1;
        end else if (rd && addr == ADDR_STAT) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn || start_cmd) begin
            busy_seen_reg <= 1'b0;
        end else if (busy_s && st_reg != H_IDLE) begin
            busy_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else if (!rd) begin
            rdata <= 16'h0000;
        end else if (addr == ADDR_CMD) begin
            rdata <= {8'h00, tx_reg};
        end else if (addr == ADDR_STAT) begin
            rdata <= {13'h0000, busy_seen_reg, done_reg,
                      st_reg != H_IDLE};
        end else if (addr == ADDR_RES) begin
            rdata <= result_reg;
        end else if (addr == ADDR_AVG) begin
            rdata <= avg_reg;
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule : sasc_host
`default_nettype wire

//--- sasc_link_if.sv
// Four-wire serial link between the converter and its controller.
`timescale 1ns/1ps
`default_nettype none
interface sasc_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic busy;
    logic busy_oe_n;

    modport device (
        input cs_n,
        input sclk,
        input din,
        output dout,
        output dout_oe_n,
        output busy,
        output busy_oe_n
    );

    modport host (
        output cs_n,
        output sclk,
        output din,
        input dout,
        input dout_oe_n,
        input busy,
        input busy_oe_n
    );
endinterface : sasc_link_if
`default_nettype wire

//--- sasc_link_sva.sv
// Checker for frame timing on the serial converter link.
`timescale 1ns/1ps
`default_nettype none
module sasc_link_sva (
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic busy,
    input wire logic busy_oe_n,
    // Converter reset
    input wire logic resetn
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [4:0] cnt_reg;
    logic [7:0] ctrl_reg;

    // Rising edges seen so far; a high select clears it at once.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg != 5'h1F) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            ctrl_reg <= 8'h00;
        end else if (cnt_reg < 5'h08) begin
            ctrl_reg <= {ctrl_reg[6:0], din};
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sclk);
    endclocking
    default disable iff (cs_n || !resetn);

    sequence s_byte_ext;
        cnt_reg == 5'h08 && ctrl_reg[1:0] == 2'h3;
    endsequence
    sequence s_busy_win;
        busy ##1 !busy;
    endsequence

    property p_busy_pulse;
        s_byte_ext |-> s_busy_win;
    endproperty
    a_busy_pulse: assert property (p_busy_pulse)
        else $error("busy pulse missing after control byte");
    property p_busy_quiet;
        cnt_reg != 5'h08 |-> !busy;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("busy high outside its slot");
    property p_busy_oe;
        busy |-> !busy_oe_n;
    endproperty
    a_busy_oe: assert property (p_busy_oe)
        else $error("busy high while not driven");
    property p_dout_zero;
        cnt_reg <= 5'h08 |-> !dout;
    endproperty
    a_dout_zero: assert property (p_dout_zero)
        else $error("data out not zero before result");
    property p_start;
        cnt_reg == 5'h00 |-> din;
    endproperty
    a_start: assert property (p_start)
        else $error("first control bit low");
    property p_cnt_max;
        cnt_reg < 5'h18;
    endproperty
    a_cnt_max: assert property (p_cnt_max)
        else $error("frame longer than 24 clocks");
    property p_oe_off;
        cnt_reg == 5'h00 |-> dout_oe_n && busy_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("outputs driven before first falling edge");
    property p_oe_on;
        cnt_reg != 5'h00 |-> !dout_oe_n && !busy_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("outputs released inside frame");
endmodule : sasc_link_sva
`default_nettype wire

//--- sasc_pkg.sv
// Shared constants, types and decode functions for the serial converter link.
package sasc_pkg;

    // ------------------------------------------------------------
    // Frame shape, counted in serial clock edges
    // ------------------------------------------------------------
    localparam int CTRL_BITS = 8;
    localparam int RES_BITS = 16;
    localparam logic [4:0] CNT_IDLE = 5'h00;
    localparam logic [4:0] CNT_ACQ = 5'h03;
    localparam logic [4:0] CNT_MODE = 5'h05;
    localparam logic [4:0] CNT_CTRL = 5'h07;
    localparam logic [4:0] CNT_BUSY = 5'h08;
    localparam logic [4:0] CNT_DEC0 = 5'h08;
    localparam logic [4:0] CNT_FIRST_OUT = 5'h09;
    localparam logic [4:0] CNT_LAST_DEC = 5'h17;
    localparam logic [4:0] CNT_LAST = 5'h18;

    // ------------------------------------------------------------
    // Control byte layout and power/clock mode codes
    // ------------------------------------------------------------
    localparam int START_POS = 7;
    localparam int SGL_POS = 2;
    localparam logic [1:0] PM_AUTO_PD = 2'h0;
    localparam logic [1:0] PM_RSV = 2'h1;
    localparam logic [1:0] PM_INT = 2'h2;
    localparam logic [1:0] PM_EXT = 2'h3;
    localparam logic [1:0] RST_PM = 2'h3;
    localparam logic [2:0] RST_CHAN = 3'h0;
    localparam logic [15:0] SAR_MSB = 16'h8000;

    // ------------------------------------------------------------
    // Controller timing and register map
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF - 1);
    localparam logic [4:0] CNT_RX_FIRST = 5'h09;
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_RES = 4'h2;
    localparam logic [3:0] ADDR_AVG = 4'h3;
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_BUSY = 2;

    typedef enum {H_IDLE, H_LOW, H_HIGH, H_TAIL} sasc_host_st_t;

    // Positive input: the same index serves single-ended and pairs.
    function automatic logic [7:0] sasc_pos_sel(input logic [2:0] ch);
        sasc_pos_sel = 8'h01 << {ch[1:0], ch[2]};
    endfunction : sasc_pos_sel

    // Negative input: bit 8 is the common pin, else the pair partner.
    function automatic logic [8:0] sasc_neg_sel(input logic [2:0] ch,
                                                input logic single);
        if (single) begin
            sasc_neg_sel = 9'h100;
        end else begin
            sasc_neg_sel = 9'h001 << {ch[1:0], ~ch[2]};
        end
    endfunction : sasc_neg_sel

endpackage : sasc_pkg

//--- sasc_sync2.sv
// Two-stage synchroniser for the link outputs seen by the controller.
`timescale 1ns/1ps
`default_nettype none
module sasc_sync2 (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Data
    input wire logic [1:0] d_async,
    output logic [1:0] q_sync
);
    logic [1:0] meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_reg <= 2'h0;
            q_sync <= 2'h0;
        end else begin
            meta_reg <= d_async;
            q_sync <= meta_reg;
        end
    end
endmodule : sasc_sync2
`default_nettype wire
